// ---- src/vm0rc_pkg.sv ----
// Purpose: Constants for the voltage monitor 0 control register block
// Assumes: One 8-bit register reached over a 32-bit AXI4-Lite slave
// Notes:   Undefined reset bits are given as 0
//
// Overview of operation
// - 8-bit control register; bit 0 enables the voltage monitor 0 reset.
// - Hardware reset with boot select 1 loads 1000 XX10b.
// - Monitor, power-on or select-0 hardware reset loads 1100 XX11b.
// - Software writes bit 2 as 0; its read value may be anything.
// - Bit 3 is read-only; writes ignored, read value undefined.
// - Boot select 1 leaves bit 6 at 0; software sets it first.
package vm0rc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] VM0RC_CTRL_INDEX = 8'h2A;
    localparam logic [7:0] VM0RC_CTRL_ADDR  = 8'(VM0RC_CTRL_INDEX * 4);

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int VM0RC_B_ENABLE   = 0;
    localparam int VM0RC_B_FILT_DIS = 1;
    localparam int VM0RC_B_RSV2     = 2;
    localparam int VM0RC_B_RSV3     = 3;
    localparam int VM0RC_B_SCLK_LO  = 4;
    localparam int VM0RC_B_SCLK_HI  = 5;
    localparam int VM0RC_B_RSV6     = 6;
    localparam int VM0RC_B_RSV7     = 7;

    // ------------------------------------------------------------
    // Reset values and write mask
    // ------------------------------------------------------------
    localparam logic [7:0] VM0RC_RST_SEL1 = 8'h82;
    localparam logic [7:0] VM0RC_RST_DFLT = 8'hC3;
    localparam logic [7:0] VM0RC_WR_MASK  = 8'hF7;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] VM0RC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] VM0RC_RESP_SLVERR = 2'h2;

endpackage

// ---- src/vm0rc_axil_slave.sv ----
// Purpose: AXI4-Lite slave front end for the single control register
// Assumes: One write and one read outstanding at most
// Notes:   Unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/100ps
`default_nettype none
module vm0rc_axil_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   wr_en,
    output logic [7:0]             wr_data,
    input  wire logic [7:0]        reg_value
);

    initial begin
        if (ADDR_W < 8) begin
            $error("ADDR_W must be at least 8");
        end
    end

    localparam logic [ADDR_W-1:0] HIT_ADDR =
        ADDR_W'(vm0rc_pkg::VM0RC_CTRL_ADDR);

    logic              aw_held;
    logic              next_aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] next_aw_addr;
    logic              w_held;
    logic              next_w_held;
    logic [7:0]        w_byte;
    logic [7:0]        next_w_byte;
    logic              w_lane0;
    logic              next_w_lane0;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              do_wr;
    logic              w_hit;
    logic              r_hit;

    // ------------------------------------------------------------
    // Handshakes; a frozen block takes nothing
    // ------------------------------------------------------------
    assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign do_wr         = clk_en && aw_held && w_held && !s_axi_bvalid;
    assign w_hit         = (aw_addr == HIT_ADDR);
    assign r_hit         = (s_axi_araddr == HIT_ADDR);
    assign wr_en         = do_wr && w_hit && w_lane0; // Lane 0 holds data
    assign wr_data       = w_byte;

    // Next state of both channels
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_byte  = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held  = 1'b1;
            next_w_byte  = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = w_hit ? vm0rc_pkg::VM0RC_RESP_OKAY
                                 : vm0rc_pkg::VM0RC_RESP_SLVERR;
        end
        if (clk_en && s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = r_hit ? {24'h000000, reg_value} : 32'h00000000;
            next_rresp  = r_hit ? vm0rc_pkg::VM0RC_RESP_OKAY
                                : vm0rc_pkg::VM0RC_RESP_SLVERR;
        end
        if (clk_en && s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held      <= 1'b0;
            aw_addr      <= '0;
            w_held       <= 1'b0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else begin
            aw_held      <= next_aw_held;
            aw_addr      <= next_aw_addr;
            w_held       <= next_w_held;
            w_byte       <= next_w_byte;
            w_lane0      <= next_w_lane0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

endmodule
`default_nettype wire

// ---- src/vm0rc_top.sv ----
// Purpose: Voltage monitor 0 control register and monitor reset request
// Assumes: Detector level and reset inputs are synchronous to clk
// Notes:   Resets override the clock enable; all other state freezes
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module vm0rc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              boot_reset_select_bit,
    input  wire logic              por_reset,
    input  wire logic              detector_below,
    output logic                   vmon0_reset_req,
    output logic                   vmon0_reset_enable,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    initial begin
        if (ADDR_W < 8 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 8 and 32");
        end
    end

    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic       next_reset_req;

    // Byte address of the register, for the read check below
    localparam logic [ADDR_W-1:0] CTRL_ADDR =
        ADDR_W'(vm0rc_pkg::VM0RC_CTRL_ADDR);

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    vm0rc_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk           (clk),
        .srst          (srst),
        .clk_en        (clk_en),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_data       (wr_data),
        .reg_value     (ctrl)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Reset sources rank hardware reset, then power-on, then monitor
    // reset, then a bus write. A write landing in a reset cycle is lost,
    // which matches a real reset wiping a half-finished store.
    always_comb begin
        next_ctrl = ctrl;
        if (srst) begin
            next_ctrl = boot_reset_select_bit
                      ? vm0rc_pkg::VM0RC_RST_SEL1
                      : vm0rc_pkg::VM0RC_RST_DFLT;
        end else if (por_reset || vmon0_reset_req) begin
            next_ctrl = vm0rc_pkg::VM0RC_RST_DFLT;
        end else if (clk_en && wr_en) begin
            // Bit 3 never stores; bit 2 and the old filter bits keep
            // whatever software wrote, so a careless write is visible.
            next_ctrl = wr_data & vm0rc_pkg::VM0RC_WR_MASK;
        end
    end

    // Monitor reset request, held while armed and below threshold
    always_comb begin
        next_reset_req = vmon0_reset_req;
        if (srst || por_reset) begin
            next_reset_req = 1'b0;
        end else if (clk_en) begin
            next_reset_req = ctrl[vm0rc_pkg::VM0RC_B_ENABLE]
                           && detector_below;
        end
    end

    // Registers; the boot select level is caught while srst is high
    always_ff @(posedge clk) begin
        ctrl            <= next_ctrl;
        vmon0_reset_req <= next_reset_req;
    end

    // Enable bit brought out for the detector side
    assign vmon0_reset_enable = ctrl[vm0rc_pkg::VM0RC_B_ENABLE];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Checks that look back with $past are meant to see across the
    // release of srst, where the reset patterns first become visible.

    sequence s_hw_rst_sel1;
        $past(srst) && $past(boot_reset_select_bit);
    endsequence

    sequence s_hw_rst_sel0;
        $past(srst) && !$past(boot_reset_select_bit);
    endsequence

    sequence s_armed;
        clk_en && !por_reset && ctrl[vm0rc_pkg::VM0RC_B_ENABLE]
            && detector_below;
    endsequence

    sequence s_bus_store;
        clk_en && wr_en && !por_reset && !vmon0_reset_req;
    endsequence

    sequence s_frozen;
        !clk_en && !por_reset && !vmon0_reset_req;
    endsequence

    a_rst_sel1_value: assert property (
        s_hw_rst_sel1 |-> ctrl == vm0rc_pkg::VM0RC_RST_SEL1
            && !ctrl[vm0rc_pkg::VM0RC_B_RSV6])
        else $error("Hardware reset with select 1 gave wrong value");

    a_rst_sel0_value: assert property (
        s_hw_rst_sel0 |-> ctrl == vm0rc_pkg::VM0RC_RST_DFLT)
        else $error("Hardware reset with select 0 gave wrong value");

    a_por_reload: assert property (
        por_reset |=> ctrl == vm0rc_pkg::VM0RC_RST_DFLT
            && !vmon0_reset_req)
        else $error("Power-on reset did not reload the register");

    a_mon_reload: assert property (
        vmon0_reset_req |=> ctrl == vm0rc_pkg::VM0RC_RST_DFLT)
        else $error("Monitor reset did not reload the register");

    a_req_raise: assert property (
        s_armed |=> vmon0_reset_req)
        else $error("Armed monitor missed a low supply");

    a_req_quiet: assert property (
        clk_en && !ctrl[vm0rc_pkg::VM0RC_B_ENABLE] |=> !vmon0_reset_req)
        else $error("Monitor reset raised while disabled");

    a_bus_store: assert property (
        s_bus_store |=> ctrl == ($past(wr_data)
            & vm0rc_pkg::VM0RC_WR_MASK))
        else $error("Register write not stored");

    a_bit3_read: assert property (
        s_axi_rvalid |-> !s_axi_rdata[vm0rc_pkg::VM0RC_B_RSV3]
            && !ctrl[vm0rc_pkg::VM0RC_B_RSV3])
        else $error("Read-only bit 3 changed");

    a_frozen_hold: assert property (
        s_frozen |=> $stable(ctrl))
        else $error("Register changed while frozen");

    // A read of the register that the bus accepts in this cycle
    sequence s_ctrl_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == CTRL_ADDR;
    endsequence

    a_read_value: assert property (
        s_ctrl_read |=> s_axi_rvalid
            && s_axi_rdata == {24'h000000, $past(ctrl)})
        else $error("Register read returned the wrong value");

    a_write_answer: assert property (
        wr_en |=> s_axi_bvalid
            && s_axi_bresp == vm0rc_pkg::VM0RC_RESP_OKAY)
        else $error("Register write not answered OKAY");

    a_req_frozen: assert property (
        !clk_en && !por_reset |=> $stable(vmon0_reset_req))
        else $error("Monitor reset request moved while frozen");

    a_rst_quiet: assert property (
        $past(srst) |-> !vmon0_reset_req && !s_axi_bvalid
            && !s_axi_rvalid)
        else $error("Outputs not quiet after hardware reset");

    a_sel1_disarmed: assert property (
        s_hw_rst_sel1 |-> !vmon0_reset_enable)
        else $error("Select 1 hardware reset left the monitor armed");

endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the voltage monitor 0 control block
// Assumes: Bus readies are combinational, so they are sampled at negedge
// Notes:   A monitor process pops expected bus answers from queues
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, srst = 1'b1, clk_en = 1'b1;
    logic        boot_reset_select_bit = 1'b0, por_reset = 1'b0;
    logic        detector_below = 1'b0, vmon0_reset_req, vmon0_reset_enable;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready = 1'b0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    int          error_cnt = 0, samples_checked = 0;
    logic [1:0]  exp_b[$];
    logic [33:0] exp_r[$];
    logic [31:0] rnd;
    logic [33:0] exp_rd;
    logic [1:0]  exp_bv;
    localparam logic [7:0] A  = vm0rc_pkg::VM0RC_CTRL_ADDR;
    localparam logic [1:0] OK = vm0rc_pkg::VM0RC_RESP_OKAY;
    localparam logic [1:0] ER = vm0rc_pkg::VM0RC_RESP_SLVERR;

    // ------------------------------------------------------------
    // Clock, design and watchdog
    // ------------------------------------------------------------
    always #4 clk = ~clk;

    vm0rc_top i_vm0rc_top (
        .clk(clk), .srst(srst), .clk_en(clk_en),
        .boot_reset_select_bit(boot_reset_select_bit),
        .por_reset(por_reset), .detector_below(detector_below),
        .vmon0_reset_req(vmon0_reset_req),
        .vmon0_reset_enable(vmon0_reset_enable),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    // A hang anywhere is cut off here rather than left running
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [33:0] seen,
                         input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 100) begin
            error_cnt++;
            end_sim();
        end
    endtask

    // Answers are stable at negedge, each handshake is seen exactly once
    always @(negedge clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            if (exp_b.size() == 0) begin
                check("bresp_extra", 34'h1, 34'h0);
            end else begin
                exp_bv = exp_b.pop_front();
                check("bresp", 34'(s_axi_bresp), 34'(exp_bv));
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_r.size() == 0) begin
                check("rdata_extra", 34'h1, 34'h0);
            end else begin
                exp_rd = exp_r.pop_front();
                check("rdata", {s_axi_rresp, s_axi_rdata}, exp_rd);
                if (exp_rd[33:32] == OK) begin
                    check("enable", 34'(vmon0_reset_enable),
                          34'(exp_rd[0]));
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bus and reset tasks
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        int   n;
        logic ta, tw, tb;
        exp_b.push_back(er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end while (((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw))
                   && n < 100);
        tmo(n);
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            tb = s_axi_bvalid;
            @(posedge clk);
            n++;
        end while (!tb && n < 100);
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
                          input logic [7:0] ed);
        int   n;
        logic t;
        exp_r.push_back({er, 24'h0, ed});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            t = s_axi_arready;
            @(posedge clk);
            n++;
        end while (!t && n < 100);
        tmo(n);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            t = s_axi_rvalid;
            @(posedge clk);
            n++;
        end while (!t && n < 100);
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask

    task automatic do_reset(input logic boot);
        boot_reset_select_bit <= boot;
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic req_is(input logic e);
        @(posedge clk);
        @(negedge clk);
        check("reset_req", 34'(vmon0_reset_req), 34'(e));
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rnd = $urandom(83);
        // Both boot strap settings give their own reset pattern
        do_reset(1'b1);
        axi_rd(A, OK, 8'h82);
        do_reset(1'b0);
        axi_rd(A, OK, 8'hC3);
        // Random patterns keep software's reserved-bit duties; bit 3 drops
        repeat (8) begin
            rnd = $urandom;
            rnd[0] = 1'b0;
            rnd[1] = 1'b1;
            rnd[2] = 1'b0;
            rnd[5:4] = 2'b00;
            axi_wr(A, rnd, 4'hF, OK);
            axi_rd(A, OK, rnd[7:0] & 8'hF7);
        end
        axi_wr(A, 32'h0000_00CA, 4'hF, OK);
        axi_rd(A, OK, 8'hC2);
        // Unmapped place and a write without its low strobe
        axi_wr(8'h10, 32'h0000_0001, 4'hF, ER);
        axi_rd(8'h10, ER, 8'h00);
        axi_wr(A, 32'h0000_0083, 4'hE, OK);
        axi_rd(A, OK, 8'hC2);
        // Disabled monitor ignores a low supply
        detector_below <= 1'b1;
        req_is(1'b0);
        // Bit 6 already set; the enable goes up once the detector has settled
        axi_wr(A, 32'h0000_00C3, 4'hF, OK);
        req_is(1'b1);
        axi_rd(A, OK, 8'hC3);
        detector_below <= 1'b0;
        req_is(1'b0);
        // Power-on reset reloads the default pattern
        axi_wr(A, 32'h0000_0002, 4'hF, OK);
        por_reset <= 1'b1;
        @(posedge clk);
        por_reset <= 1'b0;
        @(posedge clk);
        axi_rd(A, OK, 8'hC3);
        // A frozen block neither raises the reset request nor takes a write address
        clk_en         <= 1'b0;
        detector_below <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("frozen_req", 34'(vmon0_reset_req), 34'h0);
        check("frozen_awready", 34'(s_axi_awready), 34'h0);
        @(posedge clk);
        clk_en         <= 1'b1;
        detector_below <= 1'b0;
        axi_rd(A, OK, 8'hC3);
        repeat (4) @(posedge clk);
        if (exp_b.size() != 0 || exp_r.size() != 0) error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
